// file: logic/ahpf_consts.svh
// constants of the output range and high-pass configuration block
// assumes inclusion by bare name from every design file that needs them
`ifndef AHPF_CONSTS_SVH
`define AHPF_CONSTS_SVH

// register offsets
`define AHPF_OFS_DEVICE_IDENTITY 8'h0D
`define AHPF_OFS_OUTPUT_RANGE_CONFIG 8'h0E
`define AHPF_OFS_HIGHPASS_CUTOFF_CONFIG 8'h0F

// output_range_config fields
`define AHPF_HPOUT_BIT 4
`define AHPF_FS_LSB 0
`define AHPF_FS_MSB 1
`define AHPF_RANGE_CFG_MASK 8'h13
`define AHPF_RANGE_CFG_RESET 8'h00

// highpass_cutoff_config fields
`define AHPF_PULSE_BYP_BIT 5
`define AHPF_PULSE_LPF_BIT 4
`define AHPF_SEL_LSB 0
`define AHPF_SEL_MSB 1
`define AHPF_CUTOFF_CFG_MASK 8'h33
`define AHPF_CUTOFF_CFG_RESET 8'h00

// identity value, arbitrary neutral code
`define AHPF_ID_DEFAULT 8'h5C

// unmapped read value
`define AHPF_UNMAPPED_RDATA 8'h00

// cut-off shifts: corner is 16 Hz divided by two to the shift
`define AHPF_SHIFT_BASE_50HZ 4'h3
`define AHPF_SHIFT_LNLP_SLOW 4'h5
`define AHPF_SHIFT_LP_SLOW 4'h6

`endif

// file: logic/ahpf_pkg.sv
// types of the output range and high-pass configuration block
// assumes ahpf_consts.svh holds the numeric constants
package ahpf_pkg;

  // output data rate code, fastest first
  typedef enum logic [2:0] {
    ODR_800 = 3'h0,
    ODR_400 = 3'h1,
    ODR_200 = 3'h2,
    ODR_100 = 3'h3,
    ODR_50 = 3'h4,
    ODR_12P5 = 3'h5,
    ODR_6P25 = 3'h6,
    ODR_1P56 = 3'h7
  } ahpf_odr_t;

  // oversampling mode
  typedef enum logic [1:0] {
    OSM_NORMAL = 2'h0,
    OSM_LNLP = 2'h1,
    OSM_HIRES = 2'h2,
    OSM_LOWPOW = 2'h3
  } ahpf_osmode_t;

  // full-scale range code
  typedef enum logic [1:0] {
    FS_2G = 2'h0,
    FS_4G = 2'h1,
    FS_8G = 2'h2,
    FS_RSVD = 2'h3
  } ahpf_fs_t;

  typedef logic signed [13:0] ahpf_axis_t;
  typedef ahpf_axis_t [2:0] ahpf_sample_t;

endpackage

// file: logic/ahpf_cutoff_if.sv
// carries the cut-off selection between the top and the cut-off table
// assumes both ends run on the same clock
interface ahpf_cutoff_if;
  logic [1:0] sel;
  ahpf_pkg::ahpf_odr_t odr;
  ahpf_pkg::ahpf_osmode_t mode;
  logic [3:0] shift;

  modport ctl (output sel, output odr, output mode, input shift);
  modport lut (input sel, input odr, input mode, output shift);
endinterface

// file: logic/ahpf_cutoff_lut.sv
// cut-off table: corner = 16 Hz / 2**shift
// assumes same clock, clock enable and reset as the top
`include "ahpf_consts.svh"

module ahpf_cutoff_lut (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  ahpf_cutoff_if.lut cut
);

  logic [3:0] base;
  logic [3:0] shift_d;
  logic [3:0] shift_q;

  always_comb begin
    base = 4'h0;
    unique case (cut.mode)
      ahpf_pkg::OSM_NORMAL: begin
        if (cut.odr <= ahpf_pkg::ODR_400) begin
          base = 4'h0;
        end else if (cut.odr >= ahpf_pkg::ODR_50) begin
          base = `AHPF_SHIFT_BASE_50HZ;
        end else begin
          base = {1'b0, cut.odr} - 4'h1;
        end
      end
      ahpf_pkg::OSM_LNLP: begin
        if (cut.odr <= ahpf_pkg::ODR_400) begin
          base = 4'h0;
        end else if (cut.odr >= ahpf_pkg::ODR_12P5) begin
          base = `AHPF_SHIFT_LNLP_SLOW;
        end else begin
          base = {1'b0, cut.odr} - 4'h1;
        end
      end
      ahpf_pkg::OSM_HIRES: begin
        base = 4'h0;
      end
      ahpf_pkg::OSM_LOWPOW: begin
        if (cut.odr >= ahpf_pkg::ODR_12P5) begin
          base = `AHPF_SHIFT_LP_SLOW;
        end else begin
          base = {1'b0, cut.odr};
        end
      end
    endcase
    shift_d = base + {2'h0, cut.sel};
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      shift_q <= 4'h0;
    end else if (ce_i) begin
      shift_q <= shift_d;
    end
  end

  assign cut.shift = shift_q;

endmodule // ahpf_cutoff_lut

// file: logic/ahpf_top.sv
// output range and high-pass configuration of the accelerometer data path
// assumes register port, samples and rate/mode come from logic on SYS_CLK_I
//
// Behaviour
// - identity register is read-only, writes never change it
// - high-pass output enable routes filtered samples to FIFO and data registers
// - high-pass output enable is bit 4, resets to 0
// - full-scale bits 1:0 pick 2g, 4g or 8g; 11 reserved
// - pulse bypass bit 5: 0 filtered, 1 unfiltered to pulse detection
// - pulse low-pass bit 4: 1 inserts low-pass filter in pulse path
// - cut-off select bits 1:0, reset 00, with rate and mode pick corner
// - normal mode corners 16 Hz down to 0.25 Hz by rate and code
// - low-noise low-power equals normal to 50 Hz, slower 0.5 Hz down
// - high-resolution corners 16, 8, 4, 2 Hz regardless of rate
// - low-power corners from 16 Hz halving per rate, down to 0.031 Hz
`include "ahpf_consts.svh"

module ahpf_top #(
  parameter logic [7:0] ID_VALUE = `AHPF_ID_DEFAULT // arbitrary value
) (
  // clock, reset, enable
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // register port from the serial interface engine
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  // sample path
  input wire logic SAMPLE_VALID_I,
  input wire ahpf_pkg::ahpf_sample_t RAW_SAMPLE_I,
  input wire ahpf_pkg::ahpf_sample_t HP_SAMPLE_I,
  input wire ahpf_pkg::ahpf_odr_t ODR_I,
  input wire ahpf_pkg::ahpf_osmode_t OSMODE_I,
  // output data and FIFO feed
  output ahpf_pkg::ahpf_sample_t OUT_SAMPLE_O,
  output logic OUT_VALID_O,
  // pulse-detection feed
  output ahpf_pkg::ahpf_sample_t PULSE_SAMPLE_O,
  output logic PULSE_VALID_O,
  // configuration outputs
  output ahpf_pkg::ahpf_fs_t FULL_SCALE_O,
  output logic [3:0] CUTOFF_SHIFT_O
);

  logic [7:0] range_cfg_q;
  logic [7:0] cutoff_cfg_q;
  logic [7:0] rdata_d;
  logic highpass_output_enable;
  logic [1:0] full_scale_select;
  logic pulse_highpass_bypass;
  logic pulse_lowpass_enable;
  logic [1:0] cutoff_select;
  logic wr_range;
  logic wr_cutoff;
  logic [1:0] fs_new;
  ahpf_pkg::ahpf_sample_t out_q;
  ahpf_pkg::ahpf_sample_t pulse_q;
  ahpf_pkg::ahpf_sample_t lpf_q;
  ahpf_pkg::ahpf_sample_t pulse_src;
  ahpf_pkg::ahpf_sample_t lpf_d;
  logic out_valid_q;
  logic pulse_valid_q;
  ahpf_pkg::ahpf_fs_t fs_q;
  logic [3:0] shift_q;

  ahpf_cutoff_if cut ();

  // register fields
  assign highpass_output_enable = range_cfg_q[`AHPF_HPOUT_BIT];
  assign full_scale_select = range_cfg_q[`AHPF_FS_MSB:`AHPF_FS_LSB];
  assign pulse_highpass_bypass = cutoff_cfg_q[`AHPF_PULSE_BYP_BIT];
  assign pulse_lowpass_enable = cutoff_cfg_q[`AHPF_PULSE_LPF_BIT];
  assign cutoff_select = cutoff_cfg_q[`AHPF_SEL_MSB:`AHPF_SEL_LSB];

  assign wr_range = REG_WR_I && (REG_ADDR_I == `AHPF_OFS_OUTPUT_RANGE_CONFIG);
  assign wr_cutoff = REG_WR_I && (REG_ADDR_I == `AHPF_OFS_HIGHPASS_CUTOFF_CONFIG);

  // reserved full-scale code keeps the previous range
  always_comb begin
    fs_new = REG_WDATA_I[`AHPF_FS_MSB:`AHPF_FS_LSB];
    if (fs_new == ahpf_pkg::FS_RSVD) begin
      fs_new = full_scale_select;
    end
  end

  // output_range_config
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      range_cfg_q <= `AHPF_RANGE_CFG_RESET;
    end else if (CE_I && wr_range) begin
      range_cfg_q <= ({REG_WDATA_I[7:2], fs_new}) & `AHPF_RANGE_CFG_MASK;
    end
  end

  // highpass_cutoff_config
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      cutoff_cfg_q <= `AHPF_CUTOFF_CFG_RESET;
    end else if (CE_I && wr_cutoff) begin
      cutoff_cfg_q <= REG_WDATA_I & `AHPF_CUTOFF_CFG_MASK;
    end
  end

  // read decode
  always_comb begin
    unique case (REG_ADDR_I)
      `AHPF_OFS_DEVICE_IDENTITY: rdata_d = ID_VALUE;
      `AHPF_OFS_OUTPUT_RANGE_CONFIG: rdata_d = range_cfg_q;
      `AHPF_OFS_HIGHPASS_CUTOFF_CONFIG: rdata_d = cutoff_cfg_q;
      default: rdata_d = `AHPF_UNMAPPED_RDATA;
    endcase
  end

  // read data holds until the next read
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (CE_I && REG_RD_I) begin
      REG_RDATA_O <= rdata_d;
    end
  end

  // read strobe answered one cycle later
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      REG_RVALID_O <= 1'b0;
    end else if (CE_I) begin
      REG_RVALID_O <= REG_RD_I;
    end
  end

  // cut-off table
  assign cut.sel = cutoff_select;
  assign cut.odr = ODR_I;
  assign cut.mode = OSMODE_I;

  ahpf_cutoff_lut u_lut (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CE_I),
    .cut(cut.lut)
  );

  // full-scale output
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      fs_q <= ahpf_pkg::FS_2G;
    end else if (CE_I) begin
      fs_q <= ahpf_pkg::ahpf_fs_t'(full_scale_select);
    end
  end

  // cut-off output, one stage behind the table
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      shift_q <= 4'h0;
    end else if (CE_I) begin
      shift_q <= cut.shift;
    end
  end

  // per-axis sample selection and pulse low-pass
  for (genvar a = 0; a < 3; a++) begin : g_axis
    assign pulse_src[a] = pulse_highpass_bypass ? RAW_SAMPLE_I[a] : HP_SAMPLE_I[a];
    assign lpf_d[a] = 14'(lpf_q[a] + ((pulse_src[a] - lpf_q[a]) >>> 1));
  end

  // output data and FIFO path
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      out_q <= '0;
    end else if (CE_I && SAMPLE_VALID_I) begin
      out_q <= highpass_output_enable ? HP_SAMPLE_I : RAW_SAMPLE_I;
    end
  end

  // output strobe follows each sample by one cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      out_valid_q <= 1'b0;
    end else if (CE_I) begin
      out_valid_q <= SAMPLE_VALID_I;
    end
  end

  // low-pass state tracks the pulse source every sample
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      lpf_q <= '0;
    end else if (CE_I && SAMPLE_VALID_I) begin
      lpf_q <= lpf_d;
    end
  end

  // pulse-detection path
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      pulse_q <= '0;
    end else if (CE_I && SAMPLE_VALID_I) begin
      pulse_q <= pulse_lowpass_enable ? lpf_d : pulse_src;
    end
  end

  // pulse strobe follows each sample by one cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      pulse_valid_q <= 1'b0;
    end else if (CE_I) begin
      pulse_valid_q <= SAMPLE_VALID_I;
    end
  end

  assign OUT_SAMPLE_O = out_q;
  assign OUT_VALID_O = out_valid_q;
  assign PULSE_SAMPLE_O = pulse_q;
  assign PULSE_VALID_O = pulse_valid_q;
  assign FULL_SCALE_O = fs_q;
  assign CUTOFF_SHIFT_O = shift_q;

endmodule // ahpf_top

// file: dv/ahpf_top_chk.sv
// port assertions of the configuration block
// assumes binding into ahpf_top, one clock
module ahpf_chk #(
  parameter logic [7:0] ID_VALUE = 8'h5C
) (
  // clock and control
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic REG_RVALID_O,
  // data path
  input wire logic SAMPLE_VALID_I,
  input wire ahpf_pkg::ahpf_odr_t ODR_I,
  input wire ahpf_pkg::ahpf_osmode_t OSMODE_I,
  input wire logic OUT_VALID_O,
  input wire logic PULSE_VALID_O,
  input wire ahpf_pkg::ahpf_fs_t FULL_SCALE_O,
  input wire logic [3:0] CUTOFF_SHIFT_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  id_read_a: assert property (CE_I && REG_RD_I && REG_ADDR_I == 8'h0D |=> REG_RDATA_O == ID_VALUE)
    else $error("identity read wrong");
  rd_answer_a: assert property (CE_I |=> REG_RVALID_O == $past(REG_RD_I))
    else $error("read answer wrong");
  rsvd_zero_a: assert property (CE_I && REG_RD_I && REG_ADDR_I[7:1] == 7'h07
    |=> !(|(REG_RDATA_O & 8'hCC))) else $error("fixed bits not zero");
  fs_legal_a: assert property (FULL_SCALE_O != ahpf_pkg::FS_RSVD)
    else $error("reserved range out");
  out_follow_a: assert property (CE_I && SAMPLE_VALID_I |=> OUT_VALID_O && PULSE_VALID_O)
    else $error("sample not passed");
  norm_fast_a: assert property ((CE_I && OSMODE_I == ahpf_pkg::OSM_NORMAL && ODR_I <= ahpf_pkg::ODR_400)
    [*3] |-> CUTOFF_SHIFT_O <= 4'h3) else $error("normal corner wrong");
  lnlp_slow_a: assert property ((CE_I && OSMODE_I == ahpf_pkg::OSM_LNLP && ODR_I >= ahpf_pkg::ODR_12P5)
    [*3] |-> CUTOFF_SHIFT_O >= 4'h5) else $error("lnlp corner wrong");
  hires_a: assert property ((CE_I && OSMODE_I == ahpf_pkg::OSM_HIRES) [*3] |-> CUTOFF_SHIFT_O <= 4'h3)
    else $error("hires corner wrong");
  lp_slow_a: assert property ((CE_I && OSMODE_I == ahpf_pkg::OSM_LOWPOW && ODR_I >= ahpf_pkg::ODR_12P5)
    [*3] |-> CUTOFF_SHIFT_O >= 4'h6) else $error("lowpow corner wrong");
endmodule // ahpf_chk

bind ahpf_top ahpf_chk #(.ID_VALUE(ID_VALUE)) i_ahpf_chk (.*);

// file: dv/ahpf_host_model.sv
// host side of the byte register port
// assumes strobes of one cycle, read data one cycle later
module ahpf_host_model (
  // clock
  input wire logic clk_i,
  // register port
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 8'hA5;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    ok = rvalid_i;
    d = rdata_i;
  endtask
endmodule // ahpf_host_model

// file: dv/tb_accel_output_range_hpf_config.sv
// random and corner tests of the configuration block
// assumes the host model drives the register port
module tb_accel_output_range_hpf_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, rvalid, ov, pv;
  logic sv = 1'b0;
  logic ce = 1'b1;
  logic [1:0] efs = 2'h0;
  ahpf_pkg::ahpf_sample_t raw = '0, hp = '0, outs, puls;
  ahpf_pkg::ahpf_odr_t odr = ahpf_pkg::ODR_800;
  ahpf_pkg::ahpf_osmode_t mode = ahpf_pkg::OSM_NORMAL;
  ahpf_pkg::ahpf_fs_t fs;
  logic [3:0] shift;
  ahpf_pkg::ahpf_axis_t lpf[3] = '{default: '0};
  logic [31:0] seed = 32'd53536;
  logic [7:0] v, w;
  int fails = 0, num_checks = 0, cyc = 0;
  ahpf_top i_ahpf_top (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .SAMPLE_VALID_I(sv),
    .RAW_SAMPLE_I(raw), .HP_SAMPLE_I(hp), .ODR_I(odr), .OSMODE_I(mode), .OUT_SAMPLE_O(outs),
    .OUT_VALID_O(ov), .PULSE_SAMPLE_O(puls), .PULSE_VALID_O(pv), .FULL_SCALE_O(fs), .CUTOFF_SHIFT_O(shift));
  ahpf_host_model i_ahpf_host_model (.clk_i(clk), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd),
    .rdata_i(rdata), .rvalid_i(rvalid));
  always #20 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [3:0] exp_shift(int m, int o, int s);
    int b;
    b = (o < 2) ? 0 : (o < 5) ? o - 1 : 3;
    if (m == 1 && o > 4) b = 5;
    if (m == 2) b = 0;
    if (m == 3) b = (o < 5) ? o : 6;
    return 4'(b + s);
  endfunction
  task automatic chk(input logic [41:0] got, input logic [41:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    i_ahpf_host_model.rd(a, d, ok);
    chk(42'(ok), 42'h1);
    chk(42'(d), 42'(e));
  endtask
  task automatic send(input logic hpo, input logic byp, input logic lpe);
    ahpf_pkg::ahpf_sample_t pex;
    ahpf_pkg::ahpf_axis_t s;
    logic [31:0] r;
    @(negedge clk);
    for (int a = 0; a < 3; a++) begin
      r = rnd();
      raw[a] = {{2{r[11]}}, r[11:0]};
      hp[a] = {{2{r[23]}}, r[23:12]};
      s = byp ? raw[a] : hp[a];
      lpf[a] = lpf[a] + ((s - lpf[a]) >>> 1);
      pex[a] = lpe ? lpf[a] : s;
    end
    sv = 1'b1;
    @(negedge clk);
    sv = 1'b0;
    chk(42'({ov, pv}), 42'h3);
    chk(outs, hpo ? hp : raw);
    chk(puls, pex);
    @(negedge clk);
    chk(42'({ov, pv}), 42'h0);
  endtask
  task automatic results();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      results();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(8'h0E, 8'h00);
    rd_chk(8'h0F, 8'h00);
    i_ahpf_host_model.wr(8'h0D, 8'hFF);
    rd_chk(8'h0D, 8'h5C);
    rd_chk(8'h20, 8'h00);
    i_ahpf_host_model.wr(8'h0E, 8'hFF);
    rd_chk(8'h0E, 8'h10);
    ce = 1'b0;
    i_ahpf_host_model.wr(8'h0E, 8'h01);
    ce = 1'b1;
    rd_chk(8'h0E, 8'h10);
    for (int i = 0; i < 24; i++) begin
      v = 8'(rnd());
      w = 8'(rnd());
      if (v[1:0] != 2'h3) efs = v[1:0];
      i_ahpf_host_model.wr(8'h0E, v);
      i_ahpf_host_model.wr(8'h0F, w);
      rd_chk(8'h0E, {3'h0, v[4], 2'h0, efs});
      rd_chk(8'h0F, w & 8'h33);
      chk(42'(fs), 42'(efs));
      send(v[4], w[5], w[4]);
    end
    for (int m = 0; m < 4; m++) begin
      for (int o = 0; o < 8; o++) begin
        for (int s = 0; s < 4; s++) begin
          i_ahpf_host_model.wr(8'h0F, 8'(s));
          mode = ahpf_pkg::ahpf_osmode_t'(m);
          odr = ahpf_pkg::ahpf_odr_t'(o);
          repeat (3) @(negedge clk);
          chk(42'(shift), 42'(exp_shift(m, o, s)));
        end
      end
    end
    results();
  end
endmodule // tb_accel_output_range_hpf_config
